// *** rtl/smc_cycle_seq.sv ***
// static memory cycle sequencer: chip select, strobes, lanes, address and data
`timescale 1ns/1ps

// Summary of operation
// - address becomes valid on the same edge that chip select goes active.
// - on a read, output enable and lane selects go active oe_delay_cycles after chip select.
// - on a read, output enable stays active read_wait - oe_delay + 1 cycles, or one cycle when read_wait is below oe_delay.
// - on a read, lane selects stay active for the same count as output enable.
// - at the end of a read, chip select drops on the edge that output enable and lanes drop.
// - after a read, the address holds for at least two more cycles, until the next request is taken.
// - on a write, data is driven on the edge that chip select goes active.
// - on a write, write enable and lanes go active we_delay + 1 cycles after chip select.
// - on a write, write enable and lanes stay active write_wait - we_delay + 1 cycles, or one cycle when write_wait is below we_delay.
// - write data stays stable one cycle after write enable drops.
// - address and write data stay unchanged one cycle after lanes drop on a write.
// - output enable delay is kept separately for each of four banks.
module smc_cycle_seq (
	input  wire logic                        i_core_clk,
	input  wire logic                        i_resetn,
	input  wire logic                        i_ce,
	input  wire logic                        i_cfg_we,
	input  wire logic [smc_pkg::BANK_W-1:0]  i_cfg_bank,
	input  wire logic [smc_pkg::WAIT_W-1:0]  i_oe_delay_config,
	input  wire logic [smc_pkg::WAIT_W-1:0]  i_read_wait_config,
	input  wire logic [smc_pkg::WAIT_W-1:0]  i_we_delay_config,
	input  wire logic [smc_pkg::WAIT_W-1:0]  i_write_wait_config,
	input  wire logic                        i_req_valid,
	input  wire logic                        i_req_write,
	input  wire logic [smc_pkg::BANK_W-1:0]  i_req_bank,
	input  wire logic [smc_pkg::ADDR_W-1:0]  i_req_addr,
	input  wire logic [smc_pkg::DATA_W-1:0]  i_req_wdata,
	input  wire logic [smc_pkg::LANE_W-1:0]  i_req_lanes,
	output logic                             o_req_ready,
	output logic                             o_rd_valid,
	output logic      [smc_pkg::DATA_W-1:0]  o_rd_data,
	output logic                             o_busy,
	output logic      [smc_pkg::BANKS-1:0]   o_chip_select_n,
	output logic                             o_output_enable_n,
	output logic                             o_write_enable_n,
	output logic      [smc_pkg::LANE_W-1:0]  o_byte_lane_select_n,
	output logic      [smc_pkg::ADDR_W-1:0]  o_addr,
	input  wire logic [smc_pkg::DATA_W-1:0]  i_data,
	output logic      [smc_pkg::DATA_W-1:0]  o_data,
	output logic                             o_data_oe
);
	import smc_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [WAIT_W:0] span(input logic [WAIT_W-1:0] total,
		input logic [WAIT_W-1:0] dly);
		// active length minus one; a wait below its delay gives one cycle
		if (total > dly) begin
			span = {1'b0, total} - {1'b0, dly};
		end else begin
			span = '0;
		end
	endfunction

	// ****************************************
	// state
	// ****************************************
	smc_state_t            st_q, st_d;
	logic [BANK_W-1:0]     bank_q, bank_d;
	logic                  cs_q, cs_d;
	logic                  oe_q, oe_d;
	logic                  we_q, we_d;
	logic                  lane_on_q, lane_on_d;
	logic [LANE_W-1:0]     lanes_q, lanes_d;
	logic [ADDR_W-1:0]     addr_q, addr_d;
	logic [DATA_W-1:0]     wdata_q, wdata_d;
	logic                  doe_q, doe_d;
	logic                  rdv_q, rdv_d;
	logic [DATA_W-1:0]     rdata_q, rdata_d;
	logic [DATA_W-1:0]     din_s1_q;
	logic [DATA_W-1:0]     din_s2_q;
	logic                  cnt_load;
	logic [WAIT_W:0]       cnt_val;
	logic                  cnt_zero;
	logic [WAIT_W-1:0]     oe_dly;
	logic [WAIT_W-1:0]     rd_wait;
	logic [WAIT_W-1:0]     we_dly;
	logic [WAIT_W-1:0]     wr_wait;
	logic [BANK_W-1:0]     sel_bank;
	logic [BANKS-1:0]      csn_q, csn_d;

	// ****************************************
	// bank wait values
	// ****************************************
	assign sel_bank = (st_q == SMC_IDLE) ? i_req_bank : bank_q;

	smc_bank_wait_regs u_regs (
		.i_core_clk          (i_core_clk),
		.i_resetn            (i_resetn),
		.i_ce                (i_ce),
		.i_cfg_we            (i_cfg_we),
		.i_cfg_bank          (i_cfg_bank),
		.i_oe_delay_config   (i_oe_delay_config),
		.i_read_wait_config  (i_read_wait_config),
		.i_we_delay_config   (i_we_delay_config),
		.i_write_wait_config (i_write_wait_config),
		.i_sel_bank          (sel_bank),
		.o_oe_delay_cycles   (oe_dly),
		.o_read_wait_cycles  (rd_wait),
		.o_we_delay_cycles   (we_dly),
		.o_write_wait_cycles (wr_wait)
	);

	// ****************************************
	// phase counter
	// ****************************************
	smc_down_counter u_cnt (
		.i_core_clk (i_core_clk),
		.i_resetn   (i_resetn),
		.i_ce       (i_ce),
		.i_load     (cnt_load),
		.i_load_val (cnt_val),
		.o_count    (),
		.o_zero     (cnt_zero)
	);

	// ****************************************
	// read data input synchroniser
	// ****************************************
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			din_s1_q <= '0;
			din_s2_q <= '0;
		end else if (i_ce) begin
			din_s1_q <= i_data;
			din_s2_q <= din_s1_q;
		end
	end

	// ****************************************
	// sequencer next state
	// ****************************************
	always_comb begin
		st_d      = st_q;
		bank_d    = bank_q;
		cs_d      = cs_q;
		oe_d      = oe_q;
		we_d      = we_q;
		lane_on_d = lane_on_q;
		lanes_d   = lanes_q;
		addr_d    = addr_q;
		wdata_d   = wdata_q;
		doe_d     = doe_q;
		rdv_d     = 1'b0;
		rdata_d   = rdata_q;
		cnt_load  = 1'b0;
		cnt_val   = '0;
		case (st_q)
			SMC_IDLE: begin
				if (i_req_valid) begin
					bank_d   = i_req_bank;
					cs_d     = 1'b1;
					addr_d   = i_req_addr;
					lanes_d  = i_req_lanes;
					cnt_load = 1'b1;
					if (i_req_write) begin
						wdata_d = i_req_wdata;
						doe_d   = 1'b1;
						cnt_val = {1'b0, we_dly};
						st_d    = SMC_WR_DLY;
					end else if (oe_dly == WAIT_ZERO) begin
						oe_d      = 1'b1;
						lane_on_d = 1'b1;
						cnt_val   = span(rd_wait, oe_dly);
						st_d      = SMC_RD_ACT;
					end else begin
						cnt_val = {1'b0, oe_dly - WAIT_ONE};
						st_d    = SMC_RD_DLY;
					end
				end
			end
			SMC_RD_DLY: begin
				if (cnt_zero) begin
					oe_d      = 1'b1;
					lane_on_d = 1'b1;
					cnt_load  = 1'b1;
					cnt_val   = span(rd_wait, oe_dly);
					st_d      = SMC_RD_ACT;
				end
			end
			SMC_RD_ACT: begin
				if (cnt_zero) begin
					oe_d      = 1'b0;
					lane_on_d = 1'b0;
					cs_d      = 1'b0;
					rdata_d   = din_s2_q;
					rdv_d     = 1'b1;
					cnt_load  = 1'b1;
					cnt_val   = HOLD_CYCLES - 1'b1;
					st_d      = SMC_HOLD;
				end
			end
			SMC_WR_DLY: begin
				if (cnt_zero) begin
					we_d      = 1'b1;
					lane_on_d = 1'b1;
					cnt_load  = 1'b1;
					cnt_val   = span(wr_wait, we_dly);
					st_d      = SMC_WR_ACT;
				end
			end
			SMC_WR_ACT: begin
				if (cnt_zero) begin
					we_d      = 1'b0;
					lane_on_d = 1'b0;
					cs_d      = 1'b0;
					cnt_load  = 1'b1;
					cnt_val   = HOLD_CYCLES - 1'b1;
					st_d      = SMC_HOLD;
				end
			end
			SMC_HOLD: begin
				if (cnt_zero) begin
					doe_d = 1'b0;
					st_d  = SMC_IDLE;
				end
			end
			default: begin
				st_d      = SMC_IDLE;
				cs_d      = 1'b0;
				oe_d      = 1'b0;
				we_d      = 1'b0;
				lane_on_d = 1'b0;
				doe_d     = 1'b0;
			end
		endcase
	end

	// ****************************************
	// sequencer state register
	// ****************************************
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_q      <= SMC_IDLE;
			bank_q    <= '0;
			cs_q      <= 1'b0;
			oe_q      <= 1'b0;
			we_q      <= 1'b0;
			lane_on_q <= 1'b0;
			lanes_q   <= '0;
			addr_q    <= '0;
			wdata_q   <= '0;
			doe_q     <= 1'b0;
			rdv_q     <= 1'b0;
			rdata_q   <= '0;
		end else if (i_ce) begin
			st_q      <= st_d;
			bank_q    <= bank_d;
			cs_q      <= cs_d;
			oe_q      <= oe_d;
			we_q      <= we_d;
			lane_on_q <= lane_on_d;
			lanes_q   <= lanes_d;
			addr_q    <= addr_d;
			wdata_q   <= wdata_d;
			doe_q     <= doe_d;
			rdv_q     <= rdv_d;
			rdata_q   <= rdata_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// ****************************************
	// chip select pins, decoded ahead of the flops
	// ****************************************
	always_comb begin
		csn_d = '1;
		if (cs_d) begin
			csn_d[bank_d] = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			csn_q <= '1;
		end else if (i_ce) begin
			csn_q <= csn_d;
		end
	end

	assign o_chip_select_n      = csn_q;

	assign o_output_enable_n    = ~oe_q;
	assign o_write_enable_n     = ~we_q;
	assign o_byte_lane_select_n = lane_on_q ? ~lanes_q : '1;
	assign o_addr               = addr_q;
	assign o_data               = wdata_q;
	assign o_data_oe            = doe_q;
	assign o_rd_valid           = rdv_q;
	assign o_rd_data            = rdata_q;
	assign o_busy               = (st_q != SMC_IDLE);
	assign o_req_ready          = (st_q == SMC_IDLE);
endmodule

// *** rtl/smc_pkg.sv ***
// package of constants and types for the static memory cycle sequencer
package smc_pkg;
	// ****************************************
	// widths
	// ****************************************
	localparam int unsigned ADDR_W   = 24;
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned LANE_W   = 4;
	localparam int unsigned WAIT_W   = 5;
	localparam int unsigned BANKS    = 4;
	localparam int unsigned BANK_W   = 2;
	// ****************************************
	// timing and reset values
	// ****************************************
	localparam real         BUS_CLOCK_PERIOD_NS = 8.0;
	localparam logic [WAIT_W-1:0] OE_DELAY_RST    = 5'h00;
	localparam logic [WAIT_W-1:0] READ_WAIT_RST   = 5'h1f;
	localparam logic [WAIT_W-1:0] WE_DELAY_RST    = 5'h00;
	localparam logic [WAIT_W-1:0] WRITE_WAIT_RST  = 5'h1f;
	localparam logic [WAIT_W-1:0] WAIT_ONE        = 5'h01;
	localparam logic [WAIT_W-1:0] WAIT_ZERO       = 5'h00;
	localparam logic [WAIT_W:0]   HOLD_CYCLES     = 6'h01;
	// ****************************************
	// sequencer states
	// ****************************************
	typedef enum logic [2:0] {
		SMC_IDLE   = 3'b000,
		SMC_RD_DLY = 3'b001,
		SMC_RD_ACT = 3'b010,
		SMC_WR_DLY = 3'b011,
		SMC_WR_ACT = 3'b100,
		SMC_HOLD   = 3'b101
	} smc_state_t;
endpackage

// *** rtl/smc_down_counter.sv ***
// down-counter that times the phases of a memory cycle
`timescale 1ns/1ps
module smc_down_counter (
	input  wire logic                      i_core_clk,
	input  wire logic                      i_resetn,
	input  wire logic                      i_ce,
	input  wire logic                      i_load,
	input  wire logic [smc_pkg::WAIT_W:0]  i_load_val,
	output logic      [smc_pkg::WAIT_W:0]  o_count,
	output logic                           o_zero
);
	import smc_pkg::*;
	logic [WAIT_W:0] cnt_q;
	logic [WAIT_W:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (i_load) begin
			cnt_d = i_load_val;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_q <= '0;
		end else if (i_ce) begin
			cnt_q <= cnt_d;
		end
	end

	assign o_count = cnt_q;
	assign o_zero  = (cnt_q == '0);
endmodule

// *** rtl/smc_bank_wait_regs.sv ***
// per-bank wait and delay settings, selected by bank index
`timescale 1ns/1ps
module smc_bank_wait_regs (
	input  wire logic                        i_core_clk,
	input  wire logic                        i_resetn,
	input  wire logic                        i_ce,
	input  wire logic                        i_cfg_we,
	input  wire logic [smc_pkg::BANK_W-1:0]  i_cfg_bank,
	input  wire logic [smc_pkg::WAIT_W-1:0]  i_oe_delay_config,
	input  wire logic [smc_pkg::WAIT_W-1:0]  i_read_wait_config,
	input  wire logic [smc_pkg::WAIT_W-1:0]  i_we_delay_config,
	input  wire logic [smc_pkg::WAIT_W-1:0]  i_write_wait_config,
	input  wire logic [smc_pkg::BANK_W-1:0]  i_sel_bank,
	output logic      [smc_pkg::WAIT_W-1:0]  o_oe_delay_cycles,
	output logic      [smc_pkg::WAIT_W-1:0]  o_read_wait_cycles,
	output logic      [smc_pkg::WAIT_W-1:0]  o_we_delay_cycles,
	output logic      [smc_pkg::WAIT_W-1:0]  o_write_wait_cycles
);
	import smc_pkg::*;
	logic [WAIT_W-1:0] oe_q [BANKS];
	logic [WAIT_W-1:0] rd_q [BANKS];
	logic [WAIT_W-1:0] wen_q [BANKS];
	logic [WAIT_W-1:0] wr_q [BANKS];
	logic [WAIT_W-1:0] oe_d [BANKS];
	logic [WAIT_W-1:0] rd_d [BANKS];
	logic [WAIT_W-1:0] wen_d [BANKS];
	logic [WAIT_W-1:0] wr_d [BANKS];

	always_comb begin
		for (int b = 0; b < BANKS; b++) begin
			oe_d[b]  = oe_q[b];
			rd_d[b]  = rd_q[b];
			wen_d[b] = wen_q[b];
			wr_d[b]  = wr_q[b];
		end
		if (i_cfg_we) begin
			oe_d[i_cfg_bank]  = i_oe_delay_config;
			rd_d[i_cfg_bank]  = i_read_wait_config;
			wen_d[i_cfg_bank] = i_we_delay_config;
			wr_d[i_cfg_bank]  = i_write_wait_config;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int b = 0; b < BANKS; b++) begin
				oe_q[b]  <= OE_DELAY_RST;
				rd_q[b]  <= READ_WAIT_RST;
				wen_q[b] <= WE_DELAY_RST;
				wr_q[b]  <= WRITE_WAIT_RST;
			end
		end else if (i_ce) begin
			for (int b = 0; b < BANKS; b++) begin
				oe_q[b]  <= oe_d[b];
				rd_q[b]  <= rd_d[b];
				wen_q[b] <= wen_d[b];
				wr_q[b]  <= wr_d[b];
			end
		end
	end

	assign o_oe_delay_cycles   = oe_q[i_sel_bank];
	assign o_read_wait_cycles  = rd_q[i_sel_bank];
	assign o_we_delay_cycles   = wen_q[i_sel_bank];
	assign o_write_wait_cycles = wr_q[i_sel_bank];
endmodule

// *** dv/smc_cycle_seq_chk.sv ***
// pin level assertion checker of the static memory cycle sequencer
`timescale 1ns/1ps
module smc_cycle_seq_chk (
	input	wire logic				i_core_clk,
	input	wire logic				i_resetn,
	input	wire logic				i_ce,
	input	wire logic				i_req_valid,
	input	wire logic				i_req_write,
	input	wire logic [smc_pkg::ADDR_W-1:0]	i_req_addr,
	input	wire logic [smc_pkg::DATA_W-1:0]	i_req_wdata,
	input	wire logic [smc_pkg::LANE_W-1:0]	i_req_lanes,
	input	wire logic				o_req_ready,
	input	wire logic				o_rd_valid,
	input	wire logic				o_busy,
	input	wire logic [smc_pkg::BANKS-1:0]	o_chip_select_n,
	input	wire logic				o_output_enable_n,
	input	wire logic				o_write_enable_n,
	input	wire logic [smc_pkg::LANE_W-1:0]	o_byte_lane_select_n,
	input	wire logic [smc_pkg::ADDR_W-1:0]	o_addr,
	input	wire logic [smc_pkg::DATA_W-1:0]	o_data,
	input	wire logic				o_data_oe
);
	import smc_pkg::*;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	// ****
	// lane mask of the running cycle
	// ****
	logic [LANE_W-1:0]	lanes_q;
	logic [LANE_W-1:0]	lanes_d;
	always_comb begin
		lanes_d = lanes_q;
		if (i_ce && i_req_valid && o_req_ready) begin
			lanes_d = i_req_lanes;
		end
	end
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			lanes_q <= 4'h0;
		end else begin
			lanes_q <= lanes_d;
		end
	end
	// ****
	// sequences and assertions
	// ****
	sequence s_take;
		i_ce && i_req_valid && o_req_ready;
	endsequence
	sequence s_rd_end;
		$rose(o_output_enable_n);
	endsequence
	sequence s_wr_end;
		$rose(o_write_enable_n);
	endsequence
	chk_addr_on_cs:
	assert property (s_take |=> !(&o_chip_select_n) && o_addr == $past(i_req_addr))
		else $error("address not valid with chip select");
	chk_wdata_on_cs:
	assert property (s_take ##0 i_req_write |=> o_data_oe && o_data == $past(i_req_wdata))
		else $error("write data not valid with chip select");
	chk_lanes_follow:
	assert property (o_byte_lane_select_n ==
		((o_output_enable_n && o_write_enable_n) ? 4'hf : ~lanes_q))
		else $error("lane selects do not follow the strobe");
	chk_cs_with_oe:
	assert property (s_rd_end |-> &o_chip_select_n)
		else $error("chip select not released with output enable");
	chk_cs_with_we:
	assert property (s_wr_end |-> &o_chip_select_n)
		else $error("chip select not released with write enable");
	chk_addr_hold_rd:
	assert property (s_rd_end |=> $stable(o_addr))
		else $error("address changed right after read strobe");
	chk_wr_hold:
	assert property (s_wr_end |-> o_data_oe && $stable(o_data) && $stable(o_addr))
		else $error("write data or address not held");
	chk_we_has_data:
	assert property ($fell(o_write_enable_n) |-> o_data_oe && $stable(o_data))
		else $error("write strobe without stable data");
	chk_rd_valid_pulse:
	assert property (s_rd_end |-> o_rd_valid ##1 !o_rd_valid)
		else $error("read valid not a single pulse");
	chk_idle_quiet:
	assert property (!o_busy |-> &o_chip_select_n && o_output_enable_n && o_write_enable_n)
		else $error("strobe active while idle");
endmodule
bind smc_cycle_seq smc_cycle_seq_chk u_chk (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
	.i_ce(i_ce), .i_req_valid(i_req_valid), .i_req_write(i_req_write),
	.i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata), .i_req_lanes(i_req_lanes),
	.o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid), .o_busy(o_busy),
	.o_chip_select_n(o_chip_select_n), .o_output_enable_n(o_output_enable_n),
	.o_write_enable_n(o_write_enable_n), .o_byte_lane_select_n(o_byte_lane_select_n),
	.o_addr(o_addr), .o_data(o_data), .o_data_oe(o_data_oe));

// *** dv/smc_sram_model.sv ***
// static memory model on the far side of the sequencer pins
`timescale 1ns/1ps
module smc_sram_model (
	input	wire logic [smc_pkg::BANKS-1:0]	i_chip_select_n,
	input	wire logic				i_output_enable_n,
	input	wire logic				i_write_enable_n,
	input	wire logic [smc_pkg::LANE_W-1:0]	i_byte_lane_select_n,
	input	wire logic [smc_pkg::ADDR_W-1:0]	i_addr,
	input	wire logic [smc_pkg::DATA_W-1:0]	i_data,
	output	logic      [smc_pkg::DATA_W-1:0]	o_data
);
	import smc_pkg::*;
	logic [DATA_W-1:0]	mem [16];
	logic [DATA_W-1:0]	last_q = 32'h0;
	logic			sel;
	assign sel = ~&i_chip_select_n;
	initial begin
		for (int i = 0; i < 16; i++) begin
			mem[i] = 32'h0;
		end
	end
	// store enabled lanes while write enable is low
	always @* begin
		if (sel && !i_write_enable_n) begin
			for (int k = 0; k < LANE_W; k++) begin
				if (!i_byte_lane_select_n[k]) begin
					mem[i_addr[7:4]][8*k+:8] = i_data[8*k+:8];
				end
			end
		end
	end
	always @(posedge i_output_enable_n) begin
		last_q = mem[i_addr[7:4]];
	end
	// drive while selected and read enabled, otherwise an unlike value
	assign o_data = (sel && !i_output_enable_n) ? mem[i_addr[7:4]] : ~last_q;
endmodule

// *** dv/smc_cycle_seq_tb_top.sv ***
// self-checking testbench of the static memory cycle sequencer
`timescale 1ns/1ps
module smc_cycle_seq_tb_top;
	import smc_pkg::*;
	typedef struct packed {
		logic		w;
		logic [1:0]	b;
		logic [23:0]	a;
		logic [31:0]	d;
		logic [3:0]	ln;
		logic [7:0]	f;
		logic [7:0]	l;
	} smc_row_t;
	// ****
	// stimulus, wiring and tables
	// ****
	logic			clk = 1'b0;
	logic			rst_n = 1'b0;
	logic			cfg_we = 1'b0;
	logic			ce = 1'b1;
	logic [BANK_W-1:0]	cfg_bank = 2'h0;
	logic [WAIT_W-1:0]	c_oe = 5'h00, c_rd = 5'h00, c_we = 5'h00, c_wr = 5'h00;
	logic			valid = 1'b0, wr = 1'b0;
	logic [BANK_W-1:0]	bank = 2'h0;
	logic [ADDR_W-1:0]	addr = 24'h0;
	logic [DATA_W-1:0]	wdata = 32'h0;
	logic [LANE_W-1:0]	lanes = 4'h0;
	logic			ready, rd_valid, busy, oe_n, we_n, data_oe;
	logic [DATA_W-1:0]	rd_data, dout, mem_q, bus;
	logic [BANKS-1:0]	cs_n;
	logic [LANE_W-1:0]	bls_n;
	logic [ADDR_W-1:0]	maddr;
	int			num_errors = 0;
	int			comparisons = 0;
	int			f, l;
	logic [19:0]		cfgs [4] = '{{5'h00, 5'h03, 5'h00, 5'h02},
		{5'h02, 5'h05, 5'h01, 5'h01}, {5'h03, 5'h02, 5'h03, 5'h06},
		{5'h01, 5'h04, 5'h02, 5'h02}};
	smc_row_t		rows [8] = '{
		'{1'b1, 2'h0, 24'h10, 32'h11223344, 4'hf, 8'h01, 8'h03},
		'{1'b1, 2'h1, 24'h20, 32'ha5a55a5a, 4'h3, 8'h02, 8'h01},
		'{1'b1, 2'h2, 24'h30, 32'hdeadbeef, 4'hf, 8'h04, 8'h04},
		'{1'b1, 2'h3, 24'h40, 32'h01020304, 4'hf, 8'h03, 8'h01},
		'{1'b0, 2'h0, 24'h10, 32'h11223344, 4'hf, 8'h00, 8'h04},
		'{1'b0, 2'h1, 24'h20, 32'h00005a5a, 4'hc, 8'h02, 8'h04},
		'{1'b0, 2'h2, 24'h30, 32'hdeadbeef, 4'hf, 8'h03, 8'h01},
		'{1'b0, 2'h3, 24'h40, 32'h01020304, 4'h5, 8'h01, 8'h04}};
	always #4 clk = ~clk;
	assign bus = data_oe ? dout : mem_q;
	smc_cycle_seq uut (.i_core_clk(clk), .i_resetn(rst_n), .i_ce(ce), .i_cfg_we(cfg_we),
		.i_cfg_bank(cfg_bank), .i_oe_delay_config(c_oe), .i_read_wait_config(c_rd),
		.i_we_delay_config(c_we), .i_write_wait_config(c_wr), .i_req_valid(valid),
		.i_req_write(wr), .i_req_bank(bank), .i_req_addr(addr), .i_req_wdata(wdata),
		.i_req_lanes(lanes), .o_req_ready(ready), .o_rd_valid(rd_valid),
		.o_rd_data(rd_data), .o_busy(busy), .o_chip_select_n(cs_n),
		.o_output_enable_n(oe_n), .o_write_enable_n(we_n), .o_byte_lane_select_n(bls_n),
		.o_addr(maddr), .i_data(bus), .o_data(dout), .o_data_oe(data_oe));
	smc_sram_model u_mem (.i_chip_select_n(cs_n), .i_output_enable_n(oe_n),
		.i_write_enable_n(we_n), .i_byte_lane_select_n(bls_n), .i_addr(maddr),
		.i_data(bus), .o_data(mem_q));
	// ****
	// tasks
	// ****
	task automatic check(input logic ok, input string what);
		comparisons++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("ERROR %0t %s", $time, what);
		end
	endtask
	task automatic op(input logic w, input logic [1:0] b, input logic [23:0] a,
		input logic [31:0] d, output int first, output int len);
		int n;
		n = 0;
		first = -1;
		len = 0;
		while (ready !== 1'b1 && n < 99) begin
			n++;
			@(negedge clk);
		end
		valid = 1'b1;
		wr = w;
		bank = b;
		addr = a;
		wdata = d;
		@(negedge clk);
		valid = 1'b0;
		for (n = 0; n < 99; n++) begin
			if ((w ? we_n : oe_n) === 1'b0) begin
				if (first < 0) first = n;
				len++;
			end else if (first >= 0) break;
			@(negedge clk);
		end
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ****
	// tests
	// ****
	initial begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		cfg_we = 1'b1;
		for (int i = 0; i < 4; i++) begin
			cfg_bank = i[1:0];
			{c_oe, c_rd, c_we, c_wr} = cfgs[i];
			@(negedge clk);
		end
		cfg_we = 1'b0;
		for (int i = 0; i < 8; i++) begin
			lanes = rows[i].ln;
			op(rows[i].w, rows[i].b, rows[i].a, rows[i].d, f, l);
			check(f == int'(rows[i].f), "strobe delay");
			check(l == int'(rows[i].l), "strobe width");
			if (!rows[i].w) check(rd_valid === 1'b1, "no read valid");
			if (!rows[i].w && l >= 3) check(rd_data === rows[i].d, "read data");
		end
		$display("table of cycles done");
		rst_n = 1'b0;
		@(negedge clk);
		check(cs_n === 4'hf && bls_n === 4'hf && oe_n === 1'b1 && we_n === 1'b1, "pins");
		check(data_oe === 1'b0 && busy === 1'b0 && ready === 1'b1, "reset state");
		rst_n = 1'b1;
		@(negedge clk);
		op(1'b0, 2'h2, 24'h10, 32'h0, f, l);
		check(f == 0 && l == 32, "reset read timing");
		check(rd_data === 32'h11223344, "reset read data");
		op(1'b1, 2'h1, 24'h50, 32'h5a5a0f0f, f, l);
		check(f == 1 && l == 32, "reset write timing");
		$display("reset defaults done");
		repeat (2) @(negedge clk);
		ce = 1'b0;
		valid = 1'b1;
		wr = 1'b0;
		bank = 2'h0;
		addr = 24'h10;
		repeat (3) @(negedge clk);
		check(ready === 1'b1 && busy === 1'b0 && cs_n === 4'hf, "take while frozen");
		ce = 1'b1;
		@(negedge clk);
		valid = 1'b0;
		check(cs_n === 4'he && oe_n === 1'b0 && maddr === 24'h10, "take after freeze");
		ce = 1'b0;
		repeat (40) @(negedge clk);
		check(cs_n === 4'he && oe_n === 1'b0 && busy === 1'b1, "strobe frozen");
		ce = 1'b1;
		op(1'b0, 2'h0, 24'h10, 32'h0, f, l);
		check(f == 0 && l == 32 && rd_data === 32'h11223344, "read after freeze");
		$display("clock enable done");
		complete_run;
	end
	initial begin
		#40000;
		num_errors++;
		$display("ERROR %0t watchdog expired", $time);
		complete_run;
	end
endmodule
